// File: core/ast_async_serial_unit.sv
// APB-mapped asynchronous serial transceiver, start/8 or 9 data/stop.
// Assumes APB inputs and the receive line are synchronous to pclk.
//
// What this block does
// - Frame: start, eight or nine data bits, stop; mode bit picks nine.
// - Start bit is zero, stop bit is one, line idles high.
// - Data bits go out and come in least significant bit first.
// - Break is line held low for whole frame times.
// - Transmitter starts frames and receiver runs only while their enable bits are set.
// - Thirteen-bit divisor, idle detect, receiver-active status, parity.
// - Shifter fed by data register, or all zeros for break; drives line if busy or enabled.
// - Completed received word moves to receive data register as a whole.
// - Each bit sampled three times and decided by majority vote.
// - Sleep bit blocks all receive status flags from setting.
// - Software sets sleep bit; hardware clears it when a message begins.
// - In idle-line wake mode an idle line clears the sleep bit.
// - In address-mark mode the top data bit marks address frames.
// - Address frame clears sleep before its stop bit and is delivered.
// - Word arriving while full sets overrun and is dropped.
// - Overrun, noise, framing clear by status read then data read.
// - Noise on any bit flags noise together with receive-full.
// - Missing stop sets framing with full; overrun alone if both.
// - Framing flag blocks further word transfers until cleared.
// - Bad parity sets parity flag; cleared by status then data read.
// - Parity type set means odd parity, clear means even.
// - Bit rate is clock divided by sixteen times the divisor.
// - Rate generator stops on zero divisor or both enables clear.
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps

module ast_async_serial_unit #(
  parameter logic [12:0] RATE_RESET = ast_pkg::RATE_RST
) (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire ast_pkg::ast_apb_req_t apb_req,
  output logic                      pready,
  output logic                      pslverr,
  output logic [31:0]               prdata,
  // Serial lines
  input  wire logic                 serial_rx_line,
  output logic                      serial_tx_line,
  output logic                      serial_tx_oe
);

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  logic [ast_pkg::RATE_W-1:0]  rate_divisor_q;
  ast_pkg::ast_ctrl_one_t      ctrl_one_q;
  ast_pkg::ast_ctrl_two_t      ctrl_two_q;
  ast_pkg::ast_status_t        stat_q, snap_q, stat_set, stat_clr;
  logic [31:0]                 prdata_q;
  logic [ast_pkg::RATE_W-1:0]  br_cnt_q;
  logic [ast_pkg::WORD_W-1:0]  tx_buf_q;
  logic [ast_pkg::FRAME_W-1:0] tx_sh_q;
  logic [3:0]                  tx_bits_q;
  logic [3:0]                  tx_ph_q;
  logic [ast_pkg::WORD_W-1:0]  tx_word;
  ast_pkg::ast_rx_state_t      rx_state_q;
  logic [3:0]                  rx_ph_q;
  logic [3:0]                  rx_idx_q;
  logic [1:0]                  rx_smp_q;
  logic [ast_pkg::WORD_W-1:0]  rx_sh_q;
  logic [ast_pkg::WORD_W-1:0]  rx_data_q;
  logic [ast_pkg::WORD_W-1:0]  rx_word;
  logic [7:0]                  idle_cnt_q;
  logic                        snap_valid_q, tx_hi_q, tx_buf_full_q;
  logic                        tx_busy_q, rx_noise_q, idle_armed_q;
  logic                        br_run, tick, tx_load, tx_finish, wr_en;
  logic                        rd_en, vote, noisy, at_vote, rx_done;
  logic                        stop_bad, addr_wake, idle_hit;

  assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign rd_en = apb_req.psel & apb_req.penable & ~apb_req.pwrite;

  // ****************************************************************
  // APB slave: zero wait states, error on unmapped offsets
  // ****************************************************************
  assign pready = 1'b1;
  assign prdata = prdata_q;

  always_comb begin
    pslverr = apb_req.psel & apb_req.penable;
    if (apb_req.paddr == ast_pkg::OFS_RATE ||
        apb_req.paddr == ast_pkg::OFS_CTRL_ONE ||
        apb_req.paddr == ast_pkg::OFS_CTRL_TWO ||
        apb_req.paddr == ast_pkg::OFS_STATUS ||
        apb_req.paddr == ast_pkg::OFS_DATA_HI ||
        apb_req.paddr == ast_pkg::OFS_DATA_LO) begin
      pslverr = 1'b0;
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (apb_req.psel & ~apb_req.penable) begin
      prdata_q <= 32'h0000_0000;
      if (apb_req.paddr == ast_pkg::OFS_RATE) begin
        prdata_q[ast_pkg::RATE_W-1:0] <= rate_divisor_q;
      end else if (apb_req.paddr == ast_pkg::OFS_CTRL_ONE) begin
        prdata_q[4:0] <= ctrl_one_q;
      end else if (apb_req.paddr == ast_pkg::OFS_CTRL_TWO) begin
        prdata_q[3:0] <= ctrl_two_q;
      end else if (apb_req.paddr == ast_pkg::OFS_STATUS) begin
        prdata_q[7:0] <= stat_q;
        prdata_q[8]   <= (rx_state_q != ast_pkg::RX_IDLE);
      end else if (apb_req.paddr == ast_pkg::OFS_DATA_HI) begin
        prdata_q[0] <= rx_data_q[8];
      end else if (apb_req.paddr == ast_pkg::OFS_DATA_LO) begin
        prdata_q[7:0] <= rx_data_q[7:0];
      end
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_divisor_q <= RATE_RESET;
      ctrl_one_q     <= '0;
    end else if (wr_en) begin
      if (apb_req.paddr == ast_pkg::OFS_RATE) begin
        rate_divisor_q <= apb_req.pwdata[ast_pkg::RATE_W-1:0];
      end else if (apb_req.paddr == ast_pkg::OFS_CTRL_ONE) begin
        ctrl_one_q <= apb_req.pwdata[4:0];
      end
    end
  end

  // Sleep bit: software write takes priority over hardware wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_two_q <= '0;
    end else if (wr_en && apb_req.paddr == ast_pkg::OFS_CTRL_TWO) begin
      ctrl_two_q <= apb_req.pwdata[3:0];
    end else if (addr_wake | (idle_hit & ~ctrl_one_q.wake_mark)) begin
      ctrl_two_q.rx_sleep_bit <= 1'b0;
    end
  end

  // ****************************************************************
  // Rate generator: one tick per sixteenth of a bit
  // ****************************************************************
  assign br_run = (rate_divisor_q != '0) &
                  (ctrl_two_q.tx_enable_bit |
                   ctrl_two_q.rx_enable_bit);
  assign tick   = br_run & (br_cnt_q <= 13'h0001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      br_cnt_q <= '0;
    end else if (!br_run) begin
      br_cnt_q <= '0;
    end else if (tick) begin
      br_cnt_q <= rate_divisor_q;
    end else begin
      br_cnt_q <= br_cnt_q - 13'h0001;
    end
  end

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  always_comb begin
    tx_word = tx_buf_q;
    if (!ctrl_one_q.nine_bit) begin
      tx_word[8] = 1'b1;
    end
    if (ctrl_one_q.parity_enable_bit) begin
      if (ctrl_one_q.nine_bit) begin
        tx_word[8] = (^tx_buf_q[7:0]) ^ ctrl_one_q.parity_type_bit;
      end else begin
        tx_word[7] = (^tx_buf_q[6:0]) ^ ctrl_one_q.parity_type_bit;
      end
    end
  end

  assign tx_load   = ~tx_busy_q & tx_ph_q == '0 & tick &
                     ctrl_two_q.tx_enable_bit &
                     (tx_buf_full_q | ctrl_two_q.send_break);
  assign tx_finish = tx_busy_q & tick & tx_ph_q == ast_pkg::PH_BIT_END &
                     tx_bits_q == 4'h1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sh_q   <= '1;
      tx_bits_q <= '0;
      tx_ph_q   <= '0;
      tx_busy_q <= 1'b0;
    end else if (tx_load) begin
      tx_busy_q <= 1'b1;
      tx_ph_q   <= '0; // Start bit gets all sixteen ticks
      tx_bits_q <= ctrl_one_q.nine_bit ? ast_pkg::BITS_NINE
                                       : ast_pkg::BITS_EIGHT;
      if (ctrl_two_q.send_break) begin
        tx_sh_q <= '0;
      end else begin
        tx_sh_q <= {1'b1, tx_word, 1'b0};
      end
    end else if (tx_busy_q && tick) begin
      tx_ph_q <= tx_ph_q + 4'h1;
      if (tx_ph_q == ast_pkg::PH_BIT_END) begin
        tx_sh_q   <= {1'b1, tx_sh_q[ast_pkg::FRAME_W-1:1]};
        tx_bits_q <= tx_bits_q - 4'h1;
        tx_busy_q <= ~tx_finish;
      end
    end
  end

  // High part held until the low write moves both as one word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_hi_q       <= 1'b0;
      tx_buf_q      <= '0;
      tx_buf_full_q <= 1'b0;
    end else begin
      if (wr_en && apb_req.paddr == ast_pkg::OFS_DATA_HI) begin
        tx_hi_q <= apb_req.pwdata[0];
      end
      if (wr_en && apb_req.paddr == ast_pkg::OFS_DATA_LO) begin
        tx_buf_q      <= {tx_hi_q, apb_req.pwdata[7:0]};
        tx_buf_full_q <= 1'b1;
      end else if (tx_load && !ctrl_two_q.send_break) begin
        tx_buf_full_q <= 1'b0;
      end
    end
  end

  assign serial_tx_line = tx_busy_q ? tx_sh_q[0] : 1'b1;
  assign serial_tx_oe   = tx_busy_q | ctrl_two_q.tx_enable_bit;

  // ****************************************************************
  // Receiver: three samples per bit, majority vote
  // ****************************************************************
  assign at_vote = tick & rx_ph_q == ast_pkg::PH_VOTE;
  assign vote    = (rx_smp_q[0] & rx_smp_q[1]) |
                   (rx_smp_q[0] & serial_rx_line) |
                   (rx_smp_q[1] & serial_rx_line);
  assign noisy   = ~((rx_smp_q[0] == rx_smp_q[1]) &
                     (rx_smp_q[1] == serial_rx_line));
  assign rx_done  = at_vote & rx_state_q == ast_pkg::RX_STOP;
  assign stop_bad = ~vote;
  assign rx_word  = ctrl_one_q.nine_bit ? rx_sh_q
                                        : {1'b0, rx_sh_q[8:1]};
  assign addr_wake = ctrl_one_q.wake_mark & ctrl_two_q.rx_sleep_bit &
                     at_vote & rx_state_q == ast_pkg::RX_DATA &
                     rx_idx_q == 4'h1 & vote;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_q <= ast_pkg::RX_IDLE;
      rx_ph_q    <= '0;
      rx_idx_q   <= '0;
      rx_smp_q   <= '0;
      rx_sh_q    <= '0;
      rx_noise_q <= 1'b0;
    end else if (!ctrl_two_q.rx_enable_bit) begin
      rx_state_q <= ast_pkg::RX_IDLE;
      rx_ph_q    <= '0;
    end else if (tick) begin
      rx_ph_q <= rx_ph_q + 4'h1;
      if (rx_ph_q == ast_pkg::PH_SAMPLE_A) begin
        rx_smp_q[0] <= serial_rx_line;
      end
      if (rx_ph_q == ast_pkg::PH_SAMPLE_B) begin
        rx_smp_q[1] <= serial_rx_line;
      end
      case (rx_state_q)
        ast_pkg::RX_IDLE: begin
          rx_ph_q <= 4'h1;
          if (!serial_rx_line) begin
            rx_state_q <= ast_pkg::RX_START;
            rx_noise_q <= 1'b0;
          end
        end
        ast_pkg::RX_START: begin
          if (at_vote) begin
            rx_noise_q <= noisy;
            rx_idx_q   <= ctrl_one_q.nine_bit ? ast_pkg::DATA_NINE
                                              : ast_pkg::DATA_EIGHT;
            rx_state_q <= vote ? ast_pkg::RX_IDLE : ast_pkg::RX_DATA;
          end
        end
        ast_pkg::RX_DATA: begin
          if (at_vote) begin
            rx_sh_q    <= {vote, rx_sh_q[8:1]};
            rx_noise_q <= rx_noise_q | noisy;
            rx_idx_q   <= rx_idx_q - 4'h1;
            if (rx_idx_q == 4'h1) begin
              rx_state_q <= ast_pkg::RX_STOP;
            end
          end
        end
        default: begin
          if (at_vote) begin
            rx_state_q <= ast_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  // Idle line: a frame time of ones; long type counts only off-frame
  assign idle_hit = idle_armed_q & tick &
                    idle_cnt_q == (ctrl_one_q.nine_bit ? ast_pkg::IDLE_NINE
                                                      : ast_pkg::IDLE_EIGHT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_q   <= '0;
      idle_armed_q <= 1'b0;
    end else if (!ctrl_two_q.rx_enable_bit) begin
      idle_cnt_q <= '0;
    end else if (tick) begin
      if (!serial_rx_line ||
          (ctrl_one_q.idle_long && rx_state_q != ast_pkg::RX_IDLE)) begin
        idle_cnt_q   <= '0;
        idle_armed_q <= idle_armed_q | ~serial_rx_line;
      end else if (idle_hit) begin
        idle_armed_q <= 1'b0;
      end else begin
        idle_cnt_q <= idle_cnt_q + 8'h01;
      end
    end
  end

  // Whole-word transfer into the receive data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_q <= '0;
    end else if (rx_done && !ctrl_two_q.rx_sleep_bit &&
                 !stat_q.rx_full_flag && !stat_q.framing_error_flag) begin
      rx_data_q <= rx_word;
    end
  end

  // ****************************************************************
  // Status flags: set wins over the read-sequence clear
  // ****************************************************************
  always_comb begin
    stat_set = '0;
    stat_clr = '0;
    if (tx_load && !ctrl_two_q.send_break) begin
      stat_set.tx_empty = 1'b1;
    end
    if (tx_finish && !tx_buf_full_q) begin
      stat_set.tx_done = 1'b1;
    end
    if (rx_done && !ctrl_two_q.rx_sleep_bit) begin
      if (stat_q.rx_full_flag) begin
        stat_set.overrun_flag = 1'b1;
      end else if (!stat_q.framing_error_flag) begin
        stat_set.rx_full_flag       = 1'b1;
        stat_set.noise_flag         = rx_noise_q | noisy;
        stat_set.framing_error_flag = stop_bad;
        stat_set.parity_error_flag  = ctrl_one_q.parity_enable_bit &
                                      ((^rx_word) !=
                                       ctrl_one_q.parity_type_bit);
      end
    end
    if (idle_hit && !ctrl_two_q.rx_sleep_bit) begin
      stat_set.idle_flag = 1'b1;
    end
    if (snap_valid_q && rd_en && apb_req.paddr == ast_pkg::OFS_DATA_LO) begin
      stat_clr = snap_q;
      stat_clr.tx_empty = 1'b0;
      stat_clr.tx_done  = 1'b0;
    end
    if (snap_valid_q && wr_en && apb_req.paddr == ast_pkg::OFS_DATA_LO) begin
      stat_clr.tx_empty = snap_q.tx_empty;
      stat_clr.tx_done  = snap_q.tx_done;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= ast_pkg::STATUS_RST;
    end else begin
      stat_q <= stat_set | (stat_q & ~stat_clr);
    end
  end

  // Flags seen by the status read arm their clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_q       <= '0;
      snap_valid_q <= 1'b0;
    end else if (rd_en && apb_req.paddr == ast_pkg::OFS_STATUS) begin
      snap_q       <= stat_q;
      snap_valid_q <= 1'b1;
    end else if ((rd_en | wr_en) &&
                 apb_req.paddr == ast_pkg::OFS_DATA_LO) begin
      snap_valid_q <= 1'b0;
    end
  end

endmodule : ast_async_serial_unit

// File: core/ast_pkg.sv
// Constants, register map and field layouts of the serial transceiver.
// Assumes an APB master with 32-bit data and word-aligned registers.
package ast_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  OFS_RATE     = 8'h00;
  localparam logic [7:0]  OFS_CTRL_ONE = 8'h04;
  localparam logic [7:0]  OFS_CTRL_TWO = 8'h08;
  localparam logic [7:0]  OFS_STATUS   = 8'h0C;
  localparam logic [7:0]  OFS_DATA_HI  = 8'h10;
  localparam logic [7:0]  OFS_DATA_LO  = 8'h14;

  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int unsigned RATE_W       = 13;
  localparam logic [12:0] RATE_RST     = 13'h0004;
  localparam logic [7:0]  STATUS_RST   = 8'hC0;
  localparam int unsigned WORD_W       = 9;
  localparam int unsigned FRAME_W      = 11;

  // ****************************************************************
  // Timing of the oversampled bit
  // ****************************************************************
  localparam logic [3:0]  PH_SAMPLE_A  = 4'h7;
  localparam logic [3:0]  PH_SAMPLE_B  = 4'h8;
  localparam logic [3:0]  PH_VOTE      = 4'h9;
  localparam logic [3:0]  PH_BIT_END   = 4'hF;
  localparam logic [3:0]  BITS_EIGHT   = 4'hA;
  localparam logic [3:0]  BITS_NINE    = 4'hB;
  localparam logic [3:0]  DATA_EIGHT   = 4'h8;
  localparam logic [3:0]  DATA_NINE    = 4'h9;
  localparam logic [7:0]  IDLE_EIGHT   = 8'hA0;
  localparam logic [7:0]  IDLE_NINE    = 8'hB0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } ast_apb_req_t;

  typedef struct packed {
    logic nine_bit;
    logic wake_mark;
    logic idle_long;
    logic parity_enable_bit;
    logic parity_type_bit;
  } ast_ctrl_one_t;

  typedef struct packed {
    logic tx_enable_bit;
    logic rx_enable_bit;
    logic rx_sleep_bit;
    logic send_break;
  } ast_ctrl_two_t;

  typedef struct packed {
    logic tx_empty;
    logic tx_done;
    logic rx_full_flag;
    logic idle_flag;
    logic overrun_flag;
    logic noise_flag;
    logic framing_error_flag;
    logic parity_error_flag;
  } ast_status_t;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } ast_rx_state_t;

endpackage : ast_pkg

// File: verification/ast_async_serial_unit_bench.sv
// Bench of the serial transceiver: APB master and remote station.
// Assumes the design answers each APB access within 20 cycles.
`timescale 1ns/1ps

module ast_async_serial_unit_bench;
  // ****************
  // Signals and instances
  // ****************
  logic                  pclk;
  logic                  presetn;
  logic                  pready;
  logic                  pslverr;
  logic                  tx;
  logic                  oe;
  logic                  rx;
  logic                  err;
  logic                  stp;
  logic                  tmo;
  logic [31:0]           prdata;
  logic [31:0]           rd;
  logic [8:0]            w;
  ast_pkg::ast_apb_req_t req;
  int                    bad_count;
  int                    check_count;

  ast_async_serial_unit u_ast_async_serial_unit (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .serial_rx_line(rx),
    .serial_tx_line(tx), .serial_tx_oe(oe));
  ast_remote_station u_ast_remote_station (
    .pclk(pclk), .tx_line(tx), .rx_line(rx));

  always #50 pclk = ~pclk;

  // ****************
  // Tasks
  // ****************
  task automatic chk(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      stop_test();
    end else begin
      rd = prdata;
      err = pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
    end
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), rd & m, e);
  endtask : rchk

  task automatic t_tx(input logic [31:0] c1, input logic [8:0] v, e);
    apb(1'b1, ast_pkg::OFS_CTRL_ONE, c1);
    apb(1'b1, ast_pkg::OFS_DATA_HI, {31'h0, v[8]});
    apb(1'b1, ast_pkg::OFS_DATA_LO, {24'h0, v[7:0]});
    u_ast_remote_station.get(w, c1[4] ? 9 : 8, stp, tmo);
    if (tmo) begin
      bad_count++;
      stop_test();
    end else begin
      chk("tx word", {23'h0, w}, {23'h0, e});
      chk("tx stop", {31'h0, stp}, 32'h1);
    end
  endtask : t_tx

  task automatic t_rx(input logic [31:0] c1, input logic [8:0] v, v2,
                      input logic s, two, input logic [31:0] est,
                      input logic [8:0] ed);
    apb(1'b1, ast_pkg::OFS_CTRL_ONE, c1);
    u_ast_remote_station.send(v, c1[4] ? 9 : 8, s);
    if (two) u_ast_remote_station.send(v2, c1[4] ? 9 : 8, 1'b1);
    rchk(ast_pkg::OFS_STATUS, 32'h2F, est);
    rchk(ast_pkg::OFS_DATA_HI, 32'h1, {31'h0, ed[8]});
    rchk(ast_pkg::OFS_DATA_LO, 32'hFF, {24'h0, ed[7:0]});
    rchk(ast_pkg::OFS_STATUS, 32'h2F, 32'h0);
  endtask : t_rx

  // ****************
  // Main sequence
  // ****************
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    req = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rchk(ast_pkg::OFS_RATE, 32'hFFFFFFFF, 32'h4);
    rchk(ast_pkg::OFS_CTRL_ONE, 32'hFFFFFFFF, 32'h0);
    rchk(ast_pkg::OFS_CTRL_TWO, 32'hFFFFFFFF, 32'h0);
    rchk(ast_pkg::OFS_STATUS, 32'hFFFFFFFF, 32'hC0);
    rchk(8'h18, 32'hFFFFFFFF, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    apb(1'b1, ast_pkg::OFS_RATE, 32'h1);
    apb(1'b1, ast_pkg::OFS_CTRL_TWO, 32'hC);
    t_tx(32'h00, 9'h0A5, 9'h0A5);
    t_tx(32'h10, 9'h13C, 9'h13C);
    t_tx(32'h03, 9'h003, 9'h083);
    t_tx(32'h02, 9'h003, 9'h003);
    t_rx(32'h00, 9'h05A, 9'h0, 1'b1, 1'b0, 32'h20, 9'h05A);
    t_rx(32'h10, 9'h1A5, 9'h0, 1'b1, 1'b0, 32'h20, 9'h1A5);
    t_rx(32'h02, 9'h001, 9'h0, 1'b1, 1'b0, 32'h21, 9'h001);
    t_rx(32'h03, 9'h001, 9'h0, 1'b1, 1'b0, 32'h20, 9'h001);
    t_rx(32'h00, 9'h011, 9'h022, 1'b1, 1'b1, 32'h28, 9'h011);
    t_rx(32'h00, 9'h033, 9'h044, 1'b0, 1'b1, 32'h2A, 9'h033);
    apb(1'b1, ast_pkg::OFS_CTRL_ONE, 32'h8);
    apb(1'b1, ast_pkg::OFS_CTRL_TWO, 32'hE);
    t_rx(32'h08, 9'h005, 9'h085, 1'b1, 1'b1, 32'h20, 9'h085);
    rchk(ast_pkg::OFS_CTRL_TWO, 32'hF, 32'hC);
    apb(1'b1, ast_pkg::OFS_CTRL_TWO, 32'h0);
    t_rx(32'h00, 9'h077, 9'h0, 1'b1, 1'b0, 32'h00, 9'h085);
    stop_test();
  end
endmodule : ast_async_serial_unit_bench

// File: verification/ast_remote_station.sv
// Remote serial station: sends frames and captures sent frames.
// Assumes divisor 1, so one bit is 16 pclk cycles.
`timescale 1ns/1ps

module ast_remote_station #(
  parameter int BIT_CYC = 16
) (
  // Clock
  input  wire logic pclk,
  // Serial lines
  input  wire logic tx_line,
  output logic      rx_line
);
  // ****************
  // Frame tasks
  // ****************
  initial rx_line = 1'b1;

  task automatic send(input logic [8:0] w, input int n, input logic s);
    @(posedge pclk);
    for (int i = 0; i < n + 2; i++) begin
      rx_line <= (i == 0) ? 1'b0 : (i > n) ? s : w[i-1];
      repeat (BIT_CYC) @(posedge pclk);
    end
    rx_line <= 1'b1;
    repeat (BIT_CYC * 11) @(posedge pclk); // Idle frame gap
  endtask : send

  task automatic get(output logic [8:0] w, input int n, output logic s,
                     output logic to);
    int k;
    k = 0;
    w = '0;
    s = 1'b0;
    while (tx_line !== 1'b0 && k < 2000) begin
      @(posedge pclk);
      k++;
    end
    to = (tx_line !== 1'b0);
    repeat (BIT_CYC / 2) @(posedge pclk);
    for (int i = 0; i <= n; i++) begin
      repeat (BIT_CYC) @(posedge pclk);
      if (i < n) w[i] = tx_line;
      else s = tx_line;
    end
    repeat (BIT_CYC) @(posedge pclk);
  endtask : get
endmodule : ast_remote_station

// File: verification/ast_serial_checker_sva.sv
// Port checker of the serial transceiver.
// Assumes divisor 1 is used, so one line bit lasts 16 pclk cycles.
`timescale 1ns/1ps

module ast_serial_checker (
  // Clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // APB
  input wire ast_pkg::ast_apb_req_t apb_req,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic [31:0]           prdata,
  // Serial lines
  input wire logic                  serial_rx_line,
  input wire logic                  serial_tx_line,
  input wire logic                  serial_tx_oe
);
  // ****************
  // Assertions
  // ****************
  logic acc;
  logic mapped;
  logic wr_two;
  assign acc = apb_req.psel && apb_req.penable;
  assign mapped = apb_req.paddr <= 8'h14 && apb_req.paddr[1:0] == 2'h0;
  assign wr_two = acc && apb_req.paddr == ast_pkg::OFS_CTRL_TWO;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_high_a: assert property (pready)
    else $error("pready low");
  unmapped_err_a: assert property (acc && !mapped |->
    pslverr && (apb_req.pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc && mapped |-> !pslverr)
    else $error("mapped access refused");
  tx_idle_a: assert property (!serial_tx_oe |-> serial_tx_line)
    else $error("undriven tx line not high");
  bit_hold_a: assert property ($changed(serial_tx_line) |=>
    $stable(serial_tx_line)[*8] ##1 $stable(serial_tx_line)[*7])
    else $error("tx bit shorter than 16 ticks");
  oe_rise_a: assert property ($rose(serial_tx_oe) |->
    $past(wr_two && apb_req.pwrite && apb_req.pwdata[3]))
    else $error("tx driven without enable write");
  oe_fall_a: assert property ($fell(serial_tx_oe) |->
    serial_tx_line)
    else $error("tx released mid frame");
  rsvd_zero_a: assert property (wr_two && !apb_req.pwrite |->
    prdata[31:4] == 28'h0)
    else $error("reserved control bits not zero");
  cover property (acc && !mapped);
  cover property ($fell(serial_tx_line));
  cover property ($fell(serial_tx_oe));
endmodule : ast_serial_checker

bind ast_async_serial_unit ast_serial_checker u_ast_serial_checker (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .serial_rx_line(serial_rx_line),
  .serial_tx_line(serial_tx_line), .serial_tx_oe(serial_tx_oe));
